// >>> verilog/qcc_consts.svh
// bit positions and reset values of the codec control registers
`ifndef QCC_CONSTS_SVH
`define QCC_CONSTS_SVH

// =====================================================================
// serial byte framing
`define QCC_BYTE_BITS 8
`define QCC_LEAD_BIT 7

// =====================================================================
// configuration word fields
`define QCC_CFG_MODE_HI 6
`define QCC_CFG_MODE_LO 5
`define QCC_CFG_SUB 4
`define QCC_CFG_CH_HI 3
`define QCC_CFG_CH_LO 2
`define QCC_CFG_SEL_HI 1
`define QCC_CFG_SEL_LO 0

// =====================================================================
// data byte fields
`define QCC_SLOT_HI 6
`define QCC_GAIN_HALF_HI 6
`define QCC_CTRL_OUT_HI 4
`define QCC_CTRL_OUT_LO 2
`define QCC_CTRL_IO1 1
`define QCC_CTRL_IO0 0

// =====================================================================
// reset values
`define QCC_CFG_RST 8'h00
`define QCC_SLOT_RST 7'h00
`define QCC_GAIN_RST 7'h00
`define QCC_CTRL_RST 5'h00
`define QCC_DIR_RST 2'h3
`define QCC_EN_RST 2'h0

`endif

// >>> verilog/qcc_pkg.sv
// types shared by the codec control register modules
package qcc_pkg;

    // =================================================================
    // decoded operating mode of the configuration word
    typedef enum logic [2:0] {
        QCC_MODE_MU,
        QCC_MODE_A,
        QCC_MODE_GAIN,
        QCC_MODE_LINE,
        QCC_MODE_RSVD
    } qcc_mode_e;

    // =================================================================
    // state of the serial shifter
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [1:0] sdi_s;
        logic [7:0] rx_sh;
        logic [3:0] cnt;
        logic [7:0] tx_sh;
        logic sdo;
        logic oe;
        logic vld;
        logic [7:0] data;
    } qcc_shift_s;

    // =================================================================
    // state of the register bank
    typedef struct packed {
        logic [7:0] cfg;
        logic law_a;
        logic delayed;
        logic [3:0][1:0] chan_en;
        logic [3:0][1:0] dir;
        logic [3:0][4:0] ctrl;
        logic [3:0][6:0] tx_slot;
        logic [3:0][6:0] rx_slot;
        logic [3:0][1:0][1:0][6:0] gain;
        logic [3:0][1:0] io_s1;
        logic [3:0][1:0] io_s2;
    } qcc_bank_s;

endpackage : qcc_pkg

// >>> verilog/qcc_byte_if.sv
// byte carrier between the serial shifter and the register bank
`timescale 1ns/1ps
interface qcc_byte_if;
    logic byte_vld;
    logic [7:0] byte_data;
    logic [7:0] tx_byte;
    logic tx_en;

    modport shifter (
        output byte_vld,
        output byte_data,
        input tx_byte,
        input tx_en
    );

    modport bank (
        input byte_vld,
        input byte_data,
        output tx_byte,
        output tx_en
    );
endinterface : qcc_byte_if

// >>> verilog/qcc_serial_shift.sv
// serial control link shifter, sampled on the core clock
`timescale 1ns/1ps
`include "qcc_consts.svh"
module qcc_serial_shift
    import qcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // serial link pins
    input wire logic serial_control_clock,
    input wire logic control_select_n,
    input wire logic serial_control_in,
    output logic serial_control_out,
    output logic serial_control_out_oe,
    // byte side
    qcc_byte_if.shifter bus
);

    // =================================================================
    // state
    qcc_shift_s r_reg;
    qcc_shift_s r_next;
    logic sel;
    logic cs_fall;
    logic sck_fall;
    logic sck_rise;

    // edges are judged from stage two and three only
    assign sel = !r_reg.cs_s[1];
    assign cs_fall = r_reg.cs_s[2] && !r_reg.cs_s[1];
    assign sck_fall = r_reg.sck_s[2] && !r_reg.sck_s[1];
    assign sck_rise = !r_reg.sck_s[2] && r_reg.sck_s[1];

    always_comb begin
        r_next = r_reg;
        r_next.vld = 1'b0;
        r_next.cs_s = {r_reg.cs_s[1:0], control_select_n};
        r_next.sck_s = {r_reg.sck_s[1:0], serial_control_clock};
        r_next.sdi_s = {r_reg.sdi_s[0], serial_control_in};
        if (!sel) begin
            r_next.cnt = 4'h0;
            r_next.oe = 1'b0;
        end else if (cs_fall) begin
            // status image is captured once, at the start of the cycle
            r_next.tx_sh = bus.tx_byte;
            r_next.oe = bus.tx_en;
            r_next.cnt = 4'h0;
        end else begin
            // msb first, sampled on falling link clock edges
            if (sck_fall && r_reg.cnt < 4'(`QCC_BYTE_BITS)) begin
                r_next.rx_sh = {r_reg.rx_sh[6:0], r_reg.sdi_s[1]};
                r_next.cnt = r_reg.cnt + 4'h1;
                if (r_reg.cnt == 4'(`QCC_BYTE_BITS - 1)) begin
                    r_next.vld = 1'b1;
                    r_next.data = {r_reg.rx_sh[6:0], r_reg.sdi_s[1]};
                end
            end
            // driven on rising edges; extra clocks shift out zeros
            if (sck_rise) begin
                r_next.sdo = r_reg.tx_sh[7];
                r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{cs_s: 3'h7, sck_s: 3'h7, default: '0};
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // =================================================================
    // outputs
    assign serial_control_out = r_reg.sdo;
    assign serial_control_out_oe = r_reg.oe;
    assign bus.byte_vld = r_reg.vld;
    assign bus.byte_data = r_reg.data;

endmodule : qcc_serial_shift

// >>> verilog/qcc_ctrl_regs.sv
// control register bank of a four channel pcm voice codec
`timescale 1ns/1ps
`include "qcc_consts.svh"
// Overview of operation
// - bytes are eight bits, msb first
// - lead one: config word; lead zero: data
// - codec law applies to all channels
// - codec bit four picks delayed timing
// - upper mode set: bit four line/gain
// - bits three-two select the channel
// - low bits set power and slot use
// - line mode: low bits set pin direction
// - gain mode bit one: transmit or receive
// - gain mode bit zero: upper or lower
// - slot register low seven bits: slot
// - slot zero aligned to frame sync
// - slot count follows bit clock rate
// - control bits four-two drive output pins
// - bits one-zero drive bidirectional outputs
// - status seven-three: selected channel pins
// - status two-zero: channels one-three pin zero
// - line mode: write and status read together
module qcc_ctrl_regs
    import qcc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int SLOT_BITS = 7,
    parameter int GAIN_BITS = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // serial control link
    input wire logic serial_control_clock,
    input wire logic control_select_n,
    input wire logic serial_control_in,
    output logic serial_control_out,
    output logic serial_control_out_oe,
    // line interface signalling pins, three per channel
    output logic [3*CHANNELS-1:0] line_out_pins,
    // bidirectional signalling pins, two per channel
    input wire logic [2*CHANNELS-1:0] line_bidir_in,
    output logic [2*CHANNELS-1:0] line_bidir_out,
    output logic [2*CHANNELS-1:0] line_bidir_oe,
    // global codec settings
    output logic alaw_sel,
    output logic delayed_timing,
    // per channel power and slot assignment
    output logic [CHANNELS-1:0] chan_power,
    output logic [CHANNELS-1:0] rx_slot_en,
    output logic [CHANNELS-1:0] tx_slot_en,
    output logic [SLOT_BITS*CHANNELS-1:0] rx_slot_num,
    output logic [SLOT_BITS*CHANNELS-1:0] tx_slot_num,
    // gain coefficients
    output logic [GAIN_BITS*CHANNELS-1:0] rx_gain_coef,
    output logic [GAIN_BITS*CHANNELS-1:0] tx_gain_coef
);

    // =================================================================
    // mode decode, used for the stored word and for incoming words
    function automatic qcc_mode_e qcc_decode(input logic [7:0] w);
        qcc_mode_e m;
        m = QCC_MODE_RSVD;
        case (w[`QCC_CFG_MODE_HI:`QCC_CFG_MODE_LO])
            2'h0: begin
                m = QCC_MODE_MU;
            end
            2'h1: begin
                m = QCC_MODE_A;
            end
            2'h2: begin
                // sub-mode: one is line interface, zero is gain
                m = w[`QCC_CFG_SUB] ? QCC_MODE_LINE : QCC_MODE_GAIN;
            end
            default: begin
                m = QCC_MODE_RSVD;
            end
        endcase
        return m;
    endfunction : qcc_decode

    // =================================================================
    // shifter
    qcc_byte_if link_bus ();

    qcc_serial_shift u_shift (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .serial_control_clock(serial_control_clock),
        .control_select_n(control_select_n),
        .serial_control_in(serial_control_in),
        .serial_control_out(serial_control_out),
        .serial_control_out_oe(serial_control_out_oe),
        .bus(link_bus.shifter)
    );

    // =================================================================
    // state
    qcc_bank_s r_reg;
    qcc_bank_s r_next;
    qcc_mode_e cur_mode;
    qcc_mode_e new_mode;
    logic [1:0] cur_ch;
    logic [1:0] new_ch;
    logic [7:0] byte_in;
    logic [7:0] status_byte;
    logic chan1_bidir_pin_zero;
    logic chan2_bidir_pin_zero;
    logic chan3_bidir_pin_zero;

    assign byte_in = link_bus.byte_data;
    assign cur_mode = qcc_decode(r_reg.cfg);
    assign new_mode = qcc_decode(byte_in);
    assign cur_ch = r_reg.cfg[`QCC_CFG_CH_HI:`QCC_CFG_CH_LO];
    assign new_ch = byte_in[`QCC_CFG_CH_HI:`QCC_CFG_CH_LO];

    always_comb begin
        r_next = r_reg;
        // pin levels pass two flops before the status image reads them
        r_next.io_s1 = line_bidir_in;
        r_next.io_s2 = r_reg.io_s1;
        if (link_bus.byte_vld) begin
            if (byte_in[`QCC_LEAD_BIT]) begin
                r_next.cfg = byte_in;
                case (new_mode)
                    QCC_MODE_MU, QCC_MODE_A: begin
                        // one law and one timing for every channel
                        r_next.law_a = (new_mode == QCC_MODE_A);
                        r_next.delayed = byte_in[`QCC_CFG_SUB];
                        // 00 down, 01 rx, 10 tx, 11 both
                        r_next.chan_en[new_ch] =
                            byte_in[`QCC_CFG_SEL_HI:`QCC_CFG_SEL_LO];
                    end
                    QCC_MODE_LINE: begin
                        // one is input, zero is output
                        r_next.dir[new_ch] =
                            byte_in[`QCC_CFG_SEL_HI:`QCC_CFG_SEL_LO];
                    end
                    QCC_MODE_GAIN: begin
                        r_next.dir = r_reg.dir;
                    end
                    default: begin
                        // reserved mode stores the word and acts on nothing
                        r_next.dir = r_reg.dir;
                    end
                endcase
            end else begin
                case (cur_mode)
                    QCC_MODE_MU, QCC_MODE_A: begin
                        // enable bits double as the slot register select
                        if (r_reg.cfg[`QCC_CFG_SEL_LO]) begin
                            r_next.rx_slot[cur_ch] =
                                byte_in[`QCC_SLOT_HI:0];
                        end
                        if (r_reg.cfg[`QCC_CFG_SEL_HI]) begin
                            r_next.tx_slot[cur_ch] =
                                byte_in[`QCC_SLOT_HI:0];
                        end
                    end
                    QCC_MODE_GAIN: begin
                        // path by bit one, half by bit zero
                        r_next.gain[cur_ch][r_reg.cfg[`QCC_CFG_SEL_HI]]
                            [r_reg.cfg[`QCC_CFG_SEL_LO]] =
                            byte_in[`QCC_GAIN_HALF_HI:0];
                    end
                    QCC_MODE_LINE: begin
                        // reserved bits six and five are dropped
                        r_next.ctrl[cur_ch] =
                            byte_in[`QCC_CTRL_OUT_HI:0];
                    end
                    default: begin
                        r_next.ctrl = r_reg.ctrl;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_reg.cfg <= `QCC_CFG_RST;
            r_reg.law_a <= 1'b0;
            r_reg.delayed <= 1'b0;
            r_reg.chan_en <= {4{`QCC_EN_RST}};
            r_reg.dir <= {4{`QCC_DIR_RST}};
            r_reg.ctrl <= {4{`QCC_CTRL_RST}};
            r_reg.tx_slot <= {4{`QCC_SLOT_RST}};
            r_reg.rx_slot <= {4{`QCC_SLOT_RST}};
            r_reg.gain <= {16{`QCC_GAIN_RST}};
            r_reg.io_s1 <= '0;
            r_reg.io_s2 <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // =================================================================
    // status image: selected channel pins plus pin zero of channels one to three
    assign chan1_bidir_pin_zero = r_reg.io_s2[1][0];
    assign chan2_bidir_pin_zero = r_reg.io_s2[2][0];
    assign chan3_bidir_pin_zero = r_reg.io_s2[3][0];

    // out-only pins read back our own drive, they have no input path
    assign status_byte = {
        r_reg.io_s2[cur_ch][0],
        r_reg.io_s2[cur_ch][1],
        r_reg.ctrl[cur_ch][2],
        r_reg.ctrl[cur_ch][3],
        r_reg.ctrl[cur_ch][4],
        chan1_bidir_pin_zero,
        chan2_bidir_pin_zero,
        chan3_bidir_pin_zero
    };

    // status leaves the device in every transfer while the stored word selects line mode
    assign link_bus.tx_byte = status_byte;
    assign link_bus.tx_en = (cur_mode == QCC_MODE_LINE);

    // =================================================================
    // global outputs
    assign alaw_sel = r_reg.law_a;
    assign delayed_timing = r_reg.delayed;

    // =================================================================
    // per channel outputs
    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
            assign line_out_pins[3*gc +: 3] =
                r_reg.ctrl[gc][`QCC_CTRL_OUT_HI:`QCC_CTRL_OUT_LO];
            // a control bit reaches the pin only while it is an output
            assign line_bidir_out[2*gc] = r_reg.ctrl[gc][`QCC_CTRL_IO0];
            assign line_bidir_out[2*gc+1] = r_reg.ctrl[gc][`QCC_CTRL_IO1];
            assign line_bidir_oe[2*gc] = !r_reg.dir[gc][0];
            assign line_bidir_oe[2*gc+1] = !r_reg.dir[gc][1];
            assign chan_power[gc] = |r_reg.chan_en[gc];
            assign rx_slot_en[gc] = r_reg.chan_en[gc][0];
            assign tx_slot_en[gc] = r_reg.chan_en[gc][1];
            // slot zero starts at frame sync; framer counts 8-bit slots
            // up to the frame length set by the bit clock
            assign rx_slot_num[SLOT_BITS*gc +: SLOT_BITS] =
                r_reg.rx_slot[gc];
            assign tx_slot_num[SLOT_BITS*gc +: SLOT_BITS] =
                r_reg.tx_slot[gc];
            // index one of the path is transmit, of the half is upper
            assign rx_gain_coef[GAIN_BITS*gc +: GAIN_BITS] =
                {r_reg.gain[gc][0][1], r_reg.gain[gc][0][0]};
            assign tx_gain_coef[GAIN_BITS*gc +: GAIN_BITS] =
                {r_reg.gain[gc][1][1], r_reg.gain[gc][1][0]};
        end
    endgenerate

endmodule : qcc_ctrl_regs

// >>> tb/qcc_ctrl_regs_assertions.sv
// concurrent checks on the codec control register bank ports
`timescale 1ns/1ps
module qcc_ctrl_regs_chk #(
    parameter int CHANNELS = 4,
    parameter int SLOT_BITS = 7,
    parameter int GAIN_BITS = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // serial control link
    input wire logic serial_control_clock,
    input wire logic control_select_n,
    input wire logic serial_control_in,
    input wire logic serial_control_out_oe,
    // signalling pins
    input wire logic [3*CHANNELS-1:0] line_out_pins,
    input wire logic [2*CHANNELS-1:0] line_bidir_out,
    input wire logic [2*CHANNELS-1:0] line_bidir_oe,
    // codec settings
    input wire logic alaw_sel,
    input wire logic delayed_timing,
    input wire logic [CHANNELS-1:0] chan_power,
    input wire logic [CHANNELS-1:0] rx_slot_en,
    input wire logic [CHANNELS-1:0] tx_slot_en,
    input wire logic [SLOT_BITS*CHANNELS-1:0] rx_slot_num,
    input wire logic [SLOT_BITS*CHANNELS-1:0] tx_slot_num,
    input wire logic [GAIN_BITS*CHANNELS-1:0] rx_gain_coef,
    input wire logic [GAIN_BITS*CHANNELS-1:0] tx_gain_coef
);
    // =================================================================
    // own byte capture, so expectations do not lean on the design
    logic [2:0] ck_reg;
    logic [7:0] sh_reg, cfg_reg;
    logic [3:0] n_reg;
    logic done_reg;
    wire [1:0] ch = sh_reg[3:2];
    wire [1:0] cc = cfg_reg[3:2];
    wire fall = ck_reg[2] & ~ck_reg[1] & ~control_select_n & ~n_reg[3];
    wire [GAIN_BITS*CHANNELS-1:0] gsel = cfg_reg[1] ? tx_gain_coef :
        rx_gain_coef;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ck_reg <= 3'h7;
            sh_reg <= 8'h00;
            cfg_reg <= 8'h00;
            n_reg <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            ck_reg <= {ck_reg[1:0], serial_control_clock};
            done_reg <= fall && n_reg == 4'h7;
            if (control_select_n)
                n_reg <= 4'h0;
            else if (fall)
                n_reg <= n_reg + 4'h1;
            if (fall)
                sh_reg <= {sh_reg[6:0], serial_control_in};
            if (done_reg && sh_reg[7])
                cfg_reg <= sh_reg;
        end
    end
    // =================================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence cfg_seen;
        done_reg && sh_reg[7];
    endsequence
    sequence data_seen;
        done_reg && !sh_reg[7];
    endsequence
    AST_CODEC_LAW: assert property (cfg_seen ##0 !sh_reg[6] |->
        ##[1:8] (alaw_sel == sh_reg[5] && delayed_timing == sh_reg[4]))
        else $error("law or timing not applied");
    AST_POWER: assert property (cfg_seen ##0 !sh_reg[6] |-> ##[1:8]
        (rx_slot_en[ch] == sh_reg[0] && tx_slot_en[ch] == sh_reg[1]
        && chan_power[ch] == (|sh_reg[1:0])))
        else $error("channel power or slot use wrong");
    AST_SLOT: assert property (data_seen ##0 !cfg_reg[6] |-> ##[1:8]
        ((!cfg_reg[0] || rx_slot_num[cc*SLOT_BITS +: 7] == sh_reg[6:0])
        && (!cfg_reg[1] || tx_slot_num[cc*SLOT_BITS +: 7] == sh_reg[6:0])))
        else $error("slot number not stored");
    AST_DIR: assert property (cfg_seen ##0 sh_reg[6:4] == 3'h5 |->
        ##[1:8] line_bidir_oe[ch*2 +: 2] == ~sh_reg[1:0])
        else $error("pin direction wrong");
    AST_GAIN: assert property (data_seen ##0 cfg_reg[6:4] == 3'h4 |->
        ##[1:8] gsel[cc*GAIN_BITS + cfg_reg[0]*7 +: 7] == sh_reg[6:0])
        else $error("gain half not stored");
    AST_CTRL: assert property (data_seen ##0 cfg_reg[6:4] == 3'h5 |->
        ##[1:8] (line_out_pins[cc*3 +: 3] == sh_reg[4:2]
        && line_bidir_out[cc*2 +: 2] == sh_reg[1:0]))
        else $error("signalling outputs wrong");
    AST_OE_ON: assert property ($fell(control_select_n) &&
        cfg_reg[6:4] == 3'h5 |-> ##[1:6] serial_control_out_oe)
        else $error("status not driven");
    AST_OE_OFF: assert property ($rose(control_select_n) |->
        ##[1:6] !serial_control_out_oe)
        else $error("serial out left driven");
endmodule : qcc_ctrl_regs_chk

bind qcc_ctrl_regs qcc_ctrl_regs_chk #(.CHANNELS(CHANNELS),
    .SLOT_BITS(SLOT_BITS), .GAIN_BITS(GAIN_BITS)) chk_u (
    .core_clk(core_clk), .rstn(rstn),
    .serial_control_clock(serial_control_clock),
    .control_select_n(control_select_n),
    .serial_control_in(serial_control_in),
    .serial_control_out_oe(serial_control_out_oe),
    .line_out_pins(line_out_pins), .line_bidir_out(line_bidir_out),
    .line_bidir_oe(line_bidir_oe), .alaw_sel(alaw_sel),
    .delayed_timing(delayed_timing), .chan_power(chan_power),
    .rx_slot_en(rx_slot_en), .tx_slot_en(tx_slot_en),
    .rx_slot_num(rx_slot_num), .tx_slot_num(tx_slot_num),
    .rx_gain_coef(rx_gain_coef), .tx_gain_coef(tx_gain_coef)
);

// >>> tb/qcc_host_model.sv
// host side of the four wire serial control link
`timescale 1ns/1ps
module qcc_host_model (
    // link pins driven by the host
    output logic serial_control_clock,
    output logic control_select_n,
    output logic serial_control_in,
    // device answer
    input wire logic serial_control_out,
    input wire logic serial_control_out_oe
);
    // clock idles high, so the first edge of a window samples
    initial begin
        serial_control_clock = 1'b1;
        control_select_n = 1'b1;
        serial_control_in = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, input int nb,
        output logic [7:0] rx);
        rx = 8'h00;
        control_select_n = 1'b0;
        serial_control_in = tx[7];
        #40;
        // 80 ns link period; data moves with the rising edge, far from
        // the falling sample, and out data is read just before the fall
        for (int i = 0; i < nb; i++) begin
            serial_control_clock = 1'b0;
            #40 serial_control_clock = 1'b1;
            if (i < 7)
                serial_control_in = tx[6-i];
            #40 rx[7-i] = serial_control_out_oe ? serial_control_out : 1'bx;
        end
        control_select_n = 1'b1;
        // released line shows no stale value
        serial_control_in = ~serial_control_in;
        #240;
    endtask : xfer
endmodule : qcc_host_model

// >>> tb/tb.sv
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
module tb;
    typedef struct {
        int k;
        logic [209:0] v;
    } qcc_note_s;
    qcc_note_s q[$];
    event res_ev;
    int mismatches = 0;
    int comparisons = 0;
    logic core_clk, rstn, al, dl, sdo, sdo_oe, e_al, e_dl;
    wire sck, csn, sdi;
    logic [11:0] lo, e_lo;
    logic [7:0] bo, boe, ext, rxb, e_bo, e_boe, lv;
    wire [7:0] bin = (boe & bo) | (~boe & ext);
    logic [3:0] pw, rxe, txe, e_rxe, e_txe;
    logic [27:0] rxs, txs, e_rxs, e_txs;
    logic [55:0] rxg, txg, e_rxg, e_txg;
    wire [209:0] img = {al, dl, pw, rxe, txe, rxs, txs, rxg, txg, lo, bo, boe};

    qcc_ctrl_regs dut_u (
        .core_clk(core_clk), .rstn(rstn), .ce(1'b1),
        .serial_control_clock(sck), .control_select_n(csn),
        .serial_control_in(sdi), .serial_control_out(sdo),
        .serial_control_out_oe(sdo_oe), .line_out_pins(lo),
        .line_bidir_in(bin), .line_bidir_out(bo), .line_bidir_oe(boe),
        .alaw_sel(al), .delayed_timing(dl), .chan_power(pw),
        .rx_slot_en(rxe), .tx_slot_en(txe), .rx_slot_num(rxs),
        .tx_slot_num(txs), .rx_gain_coef(rxg), .tx_gain_coef(txg)
    );
    qcc_host_model host_u (
        .serial_control_clock(sck), .control_select_n(csn),
        .serial_control_in(sdi), .serial_control_out(sdo),
        .serial_control_out_oe(sdo_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // =================================================================
    // helpers
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] b, input int nb = 8);
        @(posedge core_clk);
        #1;
        host_u.xfer(b, nb, rxb);
    endtask : wr
    task automatic post();
        repeat (2) @(posedge core_clk);
        // look after the edge, so registered outputs have settled
        #1;
        q.push_back('{0, {e_al, e_dl, e_rxe | e_txe, e_rxe, e_txe, e_rxs,
            e_txs, e_rxg, e_txg, e_lo, e_bo, e_boe}});
        -> res_ev;
    endtask : post

    // =================================================================
    // monitor: oldest note against what the outputs show
    initial begin
        qcc_note_s n;
        forever begin
            @(res_ev);
            while (q.size() > 0) begin
                n = q.pop_front();
                comparisons++;
                if ((n.k ? {202'h0, rxb} : img) !== n.v) begin
                    mismatches++;
                    $display("CHECK FAILED at %0t: item %0d", $time, n.k);
                end
            end
        end
    end

    initial begin
        repeat (50000) @(posedge core_clk);
        mismatches++;
        finish_test();
    end

    // =================================================================
    // main sequence
    initial begin
        logic [7:0] c;
        logic [6:0] d;
        int s;
        rstn = 1'b0;
        ext = 8'h00;
        {e_al, e_dl, e_rxe, e_txe, e_rxs, e_txs} = '0;
        {e_rxg, e_txg, e_lo, e_bo, e_boe} = '0;
        s = $urandom(32'h0E66B973);
        repeat (3) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        post();
        $display("test reset done");
        // mode field kept off the reserved code throughout
        for (int ch = 0; ch < 4; ch++) begin
            c = {2'h2, ch[0], ch[1], ch[1:0], ch[1:0]};
            wr(c);
            e_al = c[5];
            e_dl = c[4];
            e_rxe[ch] = c[0];
            e_txe[ch] = c[1];
            post();
            d = (ch == 3) ? 7'h7F : 7'($urandom);
            wr({1'b0, d});
            if (c[0])
                e_rxs[ch*7 +: 7] = d;
            if (c[1])
                e_txs[ch*7 +: 7] = d;
            post();
        end
        $display("test codec done");
        for (int k = 0; k < 4; k++) begin
            d = 7'($urandom);
            wr({6'h32, k[1:0]});
            wr({1'b0, d});
            if (k[1])
                e_txg[28 + k[0]*7 +: 7] = d;
            else
                e_rxg[28 + k[0]*7 +: 7] = d;
            post();
        end
        $display("test gain done");
        for (int ch = 0; ch < 4; ch++) begin
            c = {4'hD, ch[1:0], 2'($urandom)};
            ext = 8'($urandom);
            wr(c);
            e_boe[ch*2 +: 2] = ~c[1:0];
            lv = (e_boe & e_bo) | (~e_boe & ext);
            d = {2'h0, 5'($urandom)};
            q.push_back('{1, {202'h0, lv[ch*2], lv[ch*2+1], e_lo[ch*3],
                e_lo[ch*3+1], e_lo[ch*3+2], lv[2], lv[4], lv[6]}});
            wr({1'b0, d});
            e_lo[ch*3 +: 3] = d[4:2];
            e_bo[ch*2 +: 2] = d[1:0];
            post();
        end
        $display("test line done");
        wr(8'h8F, 5);
        post();
        $display("test short window done");
        // let the monitor drain the last notes first
        @(posedge core_clk);
        finish_test();
    end
endmodule : tb
